// ---- ssl_regs.vh ----
`ifndef SSL_REGS_VH
`define SSL_REGS_VH

// ----------------------------------------
// Bus map (byte addresses)
// ----------------------------------------
`define SSL_ADDR_W          8
`define SSL_ADDR_LATCH_LAST 8'h1C
`define SSL_ADDR_CTRL       8'h20
`define SSL_ADDR_STATUS     8'h24
`define SSL_ADDR_COUNT      8'h28
`define SSL_ADDR_FRAC       8'h2C
`define SSL_ADDR_RSET       8'h30
`define SSL_ADDR_SHIFT      8'h34
`define SSL_IDX_HI          4
`define SSL_IDX_LO          2

// ----------------------------------------
// Control register
// ----------------------------------------
`define SSL_CTRL_RESET      32'h0000_0001
`define SSL_CTRL_LINK_EN    0
`define SSL_CTRL_CLR_COUNT  1

// ----------------------------------------
// Serial word layout
// ----------------------------------------
`define SSL_WORD_BITS       6'h20
`define SSL_SEL_HI          2
`define SSL_SEL_LO          0
`define SSL_RAMP_BIT        31
`define SSL_MUX_HI          30
`define SSL_MUX_LO          27
`define SSL_INT_HI          26
`define SSL_INT_LO          15
`define SSL_FMSB_HI         14
`define SSL_FMSB_LO         3
`define SSL_FLSB_HI         27
`define SSL_FLSB_LO         15
`define SSL_CPI_HI          27
`define SSL_CPI_LO          24
`define SSL_HALVER_BIT      21
`define SSL_DOUBLER_BIT     20
`define SSL_RCNT_HI         19
`define SSL_RCNT_LO         15
`define SSL_LATCH_FRAC_INT  3'h0
`define SSL_LATCH_FRAC_LSB  3'h1
`define SSL_LATCH_RDIV      3'h2
`define SSL_R_ZERO_CODE     5'h00
`define SSL_R_MAX           6'h20

// ----------------------------------------
// Monitor output selections
// ----------------------------------------
`define SSL_MON_ZERO        4'h0
`define SSL_MON_LOCK        4'h1
`define SSL_MON_SCALED_RF   4'h2
`define SSL_MON_SCALED_REF  4'h3
`define SSL_MON_MOD_DATA    4'h4
`define SSL_MON_ONE         4'h5

`endif

// ---- ssl_sync.v ----
`timescale 1ns/1ps
// ----------------------------------------
// Two-stage level synchroniser
// ----------------------------------------
module ssl_sync
(
  input  wire CLK,
  input  wire RESET,
  input  wire D,
  output reg  Q
);
  reg meta_reg;

  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      meta_reg <= 1'b0;
      Q        <= 1'b0;
    end
    else
    begin
      meta_reg <= D;
      Q        <= meta_reg;
    end
  end
endmodule

// ---- ssl_top.v ----
// What this block does
// - Serial data sampled into 32-bit shift register on each serial clock rise.
// - Lowest three word bits carry the latch select code, sent last.
// - Load strobe rise copies shift register into exactly one of eight latches.
// - Select code decodes as plain binary index, 000 to latch 0, 111 to 7.
// - Double-buffered settings wait for a later latch 0 write before acting.
// - Host writes latch 1 then latch 0; change starts at latch 0 load.
// - Fractional numerator is 25-bit unsigned over modulus two to the 25.
// - Integer divide value is 12 bits; host keeps it within 23 to 4095.
// - Reference counter is 5 bits and divides by any ratio 1 to 32.
// - Comparison rate is ref times (1+doubler) over R times (1+halver).
// - Chip enable low powers down and puts charge pump in high impedance.
// - Four-bit output select picks zero, lock detect, scaled RF, scaled ref, modulation data or one.
// - Numerator is 12-bit high part times 2^13 plus 13-bit low part.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "ssl_regs.vh"

module ssl_top
(
  input  wire        CLK,
  input  wire        RESET,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        SER_CLK,
  input  wire        SER_DATA,
  input  wire        LOAD_STROBE,
  input  wire        CHIP_ENABLE,
  input  wire        MODULATION_DATA_IN,
  input  wire        REF_IN,
  input  wire        RF_FEEDBACK_IN,
  input  wire        LOCK_DETECT_IN,
  output reg         SELECTABLE_MONITOR_OUTPUT,
  output reg         CHARGE_PUMP_OE,
  output reg         POWERED_DOWN,
  output reg         FREQ_UPDATE,
  output reg         RAMP_ENABLE,
  output reg  [11:0] INT_VALUE,
  output reg  [24:0] FRAC_VALUE,
  output reg  [4:0]  R_COUNT,
  output reg         REF_DOUBLER,
  output reg         REF_HALVER,
  output reg  [3:0]  CP_CURRENT,
  output reg         COMPARE_TICK,
  output reg         MOD_DATA_OUT
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire ser_clk_s;
  wire ser_data_s;
  wire load_s;
  wire ce_s;
  wire mod_s;
  wire ref_s;
  wire rf_s;
  wire lock_s;

  ssl_sync u_sync_sclk (.CLK(CLK), .RESET(RESET), .D(SER_CLK),            .Q(ser_clk_s));
  ssl_sync u_sync_sdat (.CLK(CLK), .RESET(RESET), .D(SER_DATA),           .Q(ser_data_s));
  ssl_sync u_sync_load (.CLK(CLK), .RESET(RESET), .D(LOAD_STROBE),        .Q(load_s));
  ssl_sync u_sync_ce   (.CLK(CLK), .RESET(RESET), .D(CHIP_ENABLE),        .Q(ce_s));
  ssl_sync u_sync_mod  (.CLK(CLK), .RESET(RESET), .D(MODULATION_DATA_IN), .Q(mod_s));
  ssl_sync u_sync_ref  (.CLK(CLK), .RESET(RESET), .D(REF_IN),             .Q(ref_s));
  ssl_sync u_sync_rf   (.CLK(CLK), .RESET(RESET), .D(RF_FEEDBACK_IN),     .Q(rf_s));
  ssl_sync u_sync_lock (.CLK(CLK), .RESET(RESET), .D(LOCK_DETECT_IN),     .Q(lock_s));

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  reg ser_clk_d_reg;
  reg load_d_reg;
  reg ref_d_reg;
  reg rf_d_reg;

  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ser_clk_d_reg <= 1'b0;
      load_d_reg    <= 1'b0;
      ref_d_reg     <= 1'b0;
      rf_d_reg      <= 1'b0;
    end
    else
    begin
      ser_clk_d_reg <= ser_clk_s;
      load_d_reg    <= load_s;
      ref_d_reg     <= ref_s;
      rf_d_reg      <= rf_s;
    end
  end

  reg  [31:0] ctrl_reg;
  wire        link_en   = ctrl_reg[`SSL_CTRL_LINK_EN];
  wire        sclk_rise = ser_clk_s & ~ser_clk_d_reg & link_en;
  wire        load_rise = load_s & ~load_d_reg & link_en;
  wire        ref_rise  = ref_s & ~ref_d_reg;
  wire        ref_fall  = ~ref_s & ref_d_reg;
  wire        rf_rise   = rf_s & ~rf_d_reg;

  // ----------------------------------------
  // Shift register
  // ----------------------------------------
  reg [31:0] shift_reg;
  reg [5:0]  bit_count_reg;

  // Data and clock share the same synchroniser depth, so the setup
  // the host gives at the pins is kept at the sampling point
  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      shift_reg     <= 32'h0000_0000;
      bit_count_reg <= 6'h00;
    end
    else
    begin
      if (sclk_rise)
        shift_reg <= {shift_reg[30:0], ser_data_s};
      if (load_rise)
        bit_count_reg <= 6'h00;
      else if (sclk_rise && bit_count_reg != `SSL_WORD_BITS)
        bit_count_reg <= bit_count_reg + 6'h01;
    end
  end

  // ----------------------------------------
  // Configuration latches
  // ----------------------------------------
  reg  [31:0] latch_reg [0:7];
  wire [2:0]  sel_code = shift_reg[`SSL_SEL_HI:`SSL_SEL_LO];
  integer     i;

  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      for (i = 0; i < 8; i = i + 1)
        latch_reg[i] <= 32'h0000_0000;
    end
    else
    begin
      for (i = 0; i < 8; i = i + 1)
        if (load_rise && sel_code == i[2:0])
          latch_reg[i] <= shift_reg;
    end
  end

  wire r0_load = load_rise && sel_code == `SSL_LATCH_FRAC_INT;

  // ----------------------------------------
  // Active settings
  // ----------------------------------------
  // Double-buffered fields move from latches 1 and 2 only on a latch 0
  // load, so a half-written frequency never reaches the divider
  wire [31:0] r1_word = latch_reg[`SSL_LATCH_FRAC_LSB];
  wire [31:0] r2_word = latch_reg[`SSL_LATCH_RDIV];
  reg  [3:0]  mux_sel_reg;

  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      INT_VALUE   <= 12'h000;
      FRAC_VALUE  <= 25'h000_0000;
      R_COUNT     <= 5'h00;
      REF_DOUBLER <= 1'b0;
      REF_HALVER  <= 1'b0;
      CP_CURRENT  <= 4'h0;
      RAMP_ENABLE <= 1'b0;
      mux_sel_reg <= `SSL_MON_ZERO;
      FREQ_UPDATE <= 1'b0;
    end
    else
    begin
      FREQ_UPDATE <= r0_load;
      if (r0_load)
      begin
        INT_VALUE   <= shift_reg[`SSL_INT_HI:`SSL_INT_LO];
        FRAC_VALUE  <= {shift_reg[`SSL_FMSB_HI:`SSL_FMSB_LO],
                        r1_word[`SSL_FLSB_HI:`SSL_FLSB_LO]};
        R_COUNT     <= r2_word[`SSL_RCNT_HI:`SSL_RCNT_LO];
        REF_DOUBLER <= r2_word[`SSL_DOUBLER_BIT];
        REF_HALVER  <= r2_word[`SSL_HALVER_BIT];
        CP_CURRENT  <= r2_word[`SSL_CPI_HI:`SSL_CPI_LO];
        RAMP_ENABLE <= shift_reg[`SSL_RAMP_BIT];
        mux_sel_reg <= shift_reg[`SSL_MUX_HI:`SSL_MUX_LO];
      end
    end
  end

  // ----------------------------------------
  // Reference path
  // ----------------------------------------
  // Code zero stands for the top ratio of 32
  wire [5:0] r_ratio = (R_COUNT == `SSL_R_ZERO_CODE) ? `SSL_R_MAX : {1'b0, R_COUNT};
  wire       ref_edge = REF_DOUBLER ? (ref_rise | ref_fall) : ref_rise;
  reg  [5:0] r_cnt_reg;
  reg        halver_reg;
  reg        scaled_ref_reg;
  reg        scaled_rf_reg;
  wire       r_wrap = ref_edge && (r_cnt_reg + 6'h01 >= r_ratio);

  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      r_cnt_reg      <= 6'h00;
      halver_reg     <= 1'b0;
      COMPARE_TICK   <= 1'b0;
      scaled_ref_reg <= 1'b0;
      scaled_rf_reg  <= 1'b0;
    end
    else if (!ce_s)
    begin
      // Dividers cleared to zero and ticks stopped while powered down
      r_cnt_reg    <= 6'h00;
      halver_reg   <= 1'b0;
      COMPARE_TICK <= 1'b0;
    end
    else
    begin
      COMPARE_TICK <= 1'b0;
      if (ref_edge)
        r_cnt_reg <= r_wrap ? 6'h00 : r_cnt_reg + 6'h01;
      if (r_wrap)
      begin
        halver_reg <= REF_HALVER ? ~halver_reg : 1'b0;
        if (!REF_HALVER || halver_reg)
        begin
          COMPARE_TICK   <= 1'b1;
          scaled_ref_reg <= ~scaled_ref_reg;
        end
      end
      if (rf_rise)
        scaled_rf_reg <= ~scaled_rf_reg;
    end
  end

  // ----------------------------------------
  // Power down, monitor and keying data
  // ----------------------------------------
  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      CHARGE_PUMP_OE            <= 1'b0;
      POWERED_DOWN              <= 1'b1;
      MOD_DATA_OUT              <= 1'b0;
      SELECTABLE_MONITOR_OUTPUT <= 1'b0;
    end
    else
    begin
      CHARGE_PUMP_OE <= ce_s;
      POWERED_DOWN   <= ~ce_s;
      MOD_DATA_OUT   <= mod_s;
      case (mux_sel_reg)
        `SSL_MON_ZERO:       SELECTABLE_MONITOR_OUTPUT <= 1'b0;
        `SSL_MON_LOCK:       SELECTABLE_MONITOR_OUTPUT <= lock_s;
        `SSL_MON_SCALED_RF:  SELECTABLE_MONITOR_OUTPUT <= scaled_rf_reg;
        `SSL_MON_SCALED_REF: SELECTABLE_MONITOR_OUTPUT <= scaled_ref_reg;
        `SSL_MON_MOD_DATA:   SELECTABLE_MONITOR_OUTPUT <= mod_s;
        `SSL_MON_ONE:        SELECTABLE_MONITOR_OUTPUT <= 1'b1;
        default:             SELECTABLE_MONITOR_OUTPUT <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // Ready is raised in the setup cycle, so each access finishes in its
  // first access-phase cycle with no wait states
  wire        setup_ph  = PSEL & ~PENABLE;
  wire        done      = PSEL & PENABLE & PREADY;
  wire        is_latch  = (PADDR <= `SSL_ADDR_LATCH_LAST) &&
                          (PADDR[1:0] == 2'b00);
  reg  [15:0] load_count_reg;
  reg  [31:0] rdata_next;
  reg         err_next;

  always @*
  begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    if (is_latch)
      rdata_next = latch_reg[PADDR[`SSL_IDX_HI:`SSL_IDX_LO]];
    else
      case (PADDR)
        `SSL_ADDR_CTRL:   rdata_next = ctrl_reg;
        `SSL_ADDR_STATUS: rdata_next = {29'h0000_0000, FREQ_UPDATE,
                                        (bit_count_reg == `SSL_WORD_BITS), ce_s};
        `SSL_ADDR_COUNT:  rdata_next = {16'h0000, load_count_reg};
        `SSL_ADDR_FRAC:   rdata_next = {7'h00, FRAC_VALUE};
        `SSL_ADDR_RSET:   rdata_next = {20'h0_0000, CP_CURRENT, 1'b0,
                                        REF_HALVER, REF_DOUBLER, R_COUNT};
        `SSL_ADDR_SHIFT:  rdata_next = shift_reg;
        default:          err_next   = 1'b1;
      endcase
    if (PWRITE && !(PADDR == `SSL_ADDR_CTRL))
      err_next = 1'b1;
    if (PWRITE)
      rdata_next = 32'h0000_0000;
  end

  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else if (setup_ph)
    begin
      PREADY  <= 1'b1;
      PRDATA  <= rdata_next;
      PSLVERR <= err_next;
    end
    else
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
  end

  // Control write and load counter; a load in the clearing cycle counts
  wire wr_ctrl   = done && PWRITE && PADDR == `SSL_ADDR_CTRL;
  wire clr_count = wr_ctrl && PWDATA[`SSL_CTRL_CLR_COUNT];

  always @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ctrl_reg       <= `SSL_CTRL_RESET;
      load_count_reg <= 16'h0000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= {31'h0000_0000, PWDATA[`SSL_CTRL_LINK_EN]};
      if (clr_count)
        load_count_reg <= load_rise ? 16'h0001 : 16'h0000;
      else if (load_rise)
        load_count_reg <= load_count_reg + 16'h0001;
    end
  end

endmodule

// ---- ssl_top_properties.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module ssl_top_properties
(
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        LOAD_STROBE,
  input wire logic        CHIP_ENABLE,
  input wire logic        POWERED_DOWN,
  input wire logic        CHARGE_PUMP_OE,
  input wire logic        COMPARE_TICK,
  input wire logic        FREQ_UPDATE,
  input wire logic        RAMP_ENABLE,
  input wire logic [11:0] INT_VALUE,
  input wire logic [24:0] FRAC_VALUE,
  input wire logic [4:0]  R_COUNT,
  input wire logic        REF_DOUBLER,
  input wire logic        REF_HALVER,
  input wire logic [3:0]  CP_CURRENT
);
  logic       le_q;
  logic [3:0] since_le;

  // Cycles since the raw strobe pin rose, saturating so it never wraps
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      le_q     <= 1'b0;
      since_le <= 4'hF;
    end
    else
    begin
      le_q     <= LOAD_STROBE;
      since_le <= (LOAD_STROBE && !le_q) ? 4'h0 : ((since_le == 4'hF) ? 4'hF : since_le + 4'h1);
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_ce_low;
    !CHIP_ENABLE [*4];
  endsequence
  // Three cycles so a tick launched as power-down lands is not blamed
  sequence s_pd_held;
    POWERED_DOWN [*3];
  endsequence

  chk_ready_after_setup: assert property (s_setup |=> PREADY)
    else $error("no ready after setup cycle");
  chk_ready_one_cycle: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  chk_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error flag without ready");
  chk_frac_held: assert property ($changed(FRAC_VALUE) |-> FREQ_UPDATE)
    else $error("active fraction changed without update");
  chk_int_held: assert property ($changed({INT_VALUE, RAMP_ENABLE}) |-> FREQ_UPDATE)
    else $error("integer or ramp changed without update");
  chk_rdiv_held: assert property ($changed({R_COUNT, REF_DOUBLER, REF_HALVER, CP_CURRENT})
    |-> FREQ_UPDATE)
    else $error("reference settings changed without update");
  chk_update_cause: assert property (FREQ_UPDATE |-> since_le < 4'hA)
    else $error("update without recent load strobe");
  chk_pd_follow: assert property (s_ce_low |=> POWERED_DOWN)
    else $error("chip enable low did not power down");
  chk_pd_quiet: assert property (s_pd_held |-> !CHARGE_PUMP_OE && !COMPARE_TICK)
    else $error("charge pump or ticks active in power down");
endmodule

bind ssl_top ssl_top_properties u_chk
(
  .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .LOAD_STROBE(LOAD_STROBE), .CHIP_ENABLE(CHIP_ENABLE),
  .POWERED_DOWN(POWERED_DOWN), .CHARGE_PUMP_OE(CHARGE_PUMP_OE), .COMPARE_TICK(COMPARE_TICK),
  .FREQ_UPDATE(FREQ_UPDATE), .RAMP_ENABLE(RAMP_ENABLE), .INT_VALUE(INT_VALUE),
  .FRAC_VALUE(FRAC_VALUE), .R_COUNT(R_COUNT), .REF_DOUBLER(REF_DOUBLER),
  .REF_HALVER(REF_HALVER), .CP_CURRENT(CP_CURRENT)
);

// ---- ssl_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Serial host model
// ----------------------------------------
module ssl_host_model
(
  input  wire logic CLK,
  output logic      SER_CLK,
  output logic      SER_DATA,
  output logic      LOAD_STROBE
);
  initial
  begin
    SER_CLK     = 1'b0;
    SER_DATA    = 1'b0;
    LOAD_STROBE = 1'b0;
  end

  // Link clock idles low between frames; 16 system clocks per bit
  task send(input logic [31:0] w);
    integer i;
    begin
      for (i = 31; i >= 0; i = i - 1)
      begin
        @(posedge CLK);
        SER_DATA <= w[i];
        repeat (7) @(posedge CLK);
        SER_CLK <= 1'b1;
        repeat (8) @(posedge CLK);
        SER_CLK <= 1'b0;
      end
      repeat (4) @(posedge CLK);
      // Released line must not keep showing the last bit
      SER_DATA    <= ~w[0];
      LOAD_STROBE <= 1'b1;
      repeat (6) @(posedge CLK);
      LOAD_STROBE <= 1'b0;
      repeat (8) @(posedge CLK);
    end
  endtask
endmodule

// ---- ssl_tb.sv ----
`timescale 1ns/1ps
`include "ssl_regs.vh"
module tb;
  logic        CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic        SER_CLK, SER_DATA, LOAD_STROBE, CHIP_ENABLE, MODULATION_DATA_IN, REF_IN;
  logic        LOCK_DETECT_IN, SELECTABLE_MONITOR_OUTPUT, CHARGE_PUMP_OE, POWERED_DOWN;
  logic        FREQ_UPDATE, RAMP_ENABLE, REF_DOUBLER, REF_HALVER, COMPARE_TICK, MOD_DATA_OUT, er;
  logic [11:0] INT_VALUE;
  logic [24:0] FRAC_VALUE;
  logic [4:0]  R_COUNT;
  logic        RF_FEEDBACK_IN;
  logic [3:0]  CP_CURRENT;
  integer      n_mismatch, comparisons, n_upd, ref_cnt, i;

  ssl_top dut
  (
    .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SER_CLK(SER_CLK),
    .SER_DATA(SER_DATA), .LOAD_STROBE(LOAD_STROBE), .CHIP_ENABLE(CHIP_ENABLE),
    .MODULATION_DATA_IN(MODULATION_DATA_IN), .REF_IN(REF_IN), .RF_FEEDBACK_IN(RF_FEEDBACK_IN),
    .LOCK_DETECT_IN(LOCK_DETECT_IN), .SELECTABLE_MONITOR_OUTPUT(SELECTABLE_MONITOR_OUTPUT),
    .CHARGE_PUMP_OE(CHARGE_PUMP_OE), .POWERED_DOWN(POWERED_DOWN), .FREQ_UPDATE(FREQ_UPDATE),
    .RAMP_ENABLE(RAMP_ENABLE), .INT_VALUE(INT_VALUE), .FRAC_VALUE(FRAC_VALUE),
    .R_COUNT(R_COUNT), .REF_DOUBLER(REF_DOUBLER), .REF_HALVER(REF_HALVER),
    .CP_CURRENT(CP_CURRENT), .COMPARE_TICK(COMPARE_TICK), .MOD_DATA_OUT(MOD_DATA_OUT)
  );
  ssl_host_model u_host
  (
    .CLK(CLK), .SER_CLK(SER_CLK), .SER_DATA(SER_DATA), .LOAD_STROBE(LOAD_STROBE)
  );

  // ----------------------------------------
  // Clock, reference and update counter
  // ----------------------------------------
  always #5 CLK = ~CLK;
  always @(posedge CLK)
  begin
    ref_cnt <= (ref_cnt == 4) ? 0 : ref_cnt + 1;
    if (ref_cnt == 4) REF_IN <= ~REF_IN;
    if (FREQ_UPDATE === 1'b1) n_upd <= n_upd + 1;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] w0(input logic [3:0] m, input logic [11:0] iv,
                                     input logic [11:0] fm);
    return {1'b0, m, iv, fm, `SSL_LATCH_FRAC_INT};
  endfunction
  function automatic logic [31:0] w2(input logic [3:0] cp, input logic t, input logic d,
                                     input logic [4:0] r);
    return {4'h0, cp, 2'h0, t, d, r, 12'h000, `SSL_LATCH_RDIV};
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    integer n;
    begin
      n = 0;
      @(posedge CLK);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= wr;
      PADDR   <= a;
      PWDATA  <= wd;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do
      begin
        @(posedge CLK);
        n = n + 1;
      end
      while (PREADY !== 1'b1 && n < 20);
      chk(32'(PREADY), 32'h1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    apb(1'b0, `SSL_ADDR_CTRL, 32'h0);
    chk(rd, `SSL_CTRL_RESET);
    apb(1'b1, 8'h04, 32'hFFFF_FFFF);
    chk(32'(er), 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk(32'(er), 32'h1);
  endtask

  task t_dbuf;
    integer u;
    begin
      u = n_upd;
      u_host.send({4'h0, 13'h1FFF, 12'h000, `SSL_LATCH_FRAC_LSB});
      u_host.send(w2(4'hA, 1'b1, 1'b1, 5'h13));
      chk(32'(FRAC_VALUE), 32'h0);
      chk(32'({R_COUNT, CP_CURRENT, REF_DOUBLER, REF_HALVER}), 32'h0);
      chk(32'(n_upd - u), 32'h0);
      u_host.send(w0(4'h0, 12'hFFF, 12'hFFF) | 32'h8000_0000);
      chk(32'(FRAC_VALUE), 32'h01FF_FFFF);
      chk(32'(INT_VALUE), 32'h0000_0FFF);
      chk(32'(RAMP_ENABLE), 32'h1);
      chk(32'({R_COUNT, CP_CURRENT, REF_DOUBLER, REF_HALVER}), 32'h0000_04EB);
      chk(32'(n_upd - u), 32'h1);
      u_host.send(w0(4'h0, 12'h017, 12'h001));
      chk(32'(FRAC_VALUE), 32'h0000_3FFF);
      chk(32'(INT_VALUE), 32'h0000_0017);
      chk(32'(RAMP_ENABLE), 32'h0);
    end
  endtask

  task t_select;
    for (i = 0; i < 8; i = i + 1)
      u_host.send({i[2:0], 26'h255_A5A3, i[2:0]});
    for (i = 0; i < 8; i = i + 1)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, {i[2:0], 26'h255_A5A3, i[2:0]});
    end
    apb(1'b0, `SSL_ADDR_SHIFT, 32'h0);
    chk(rd, {3'h7, 26'h255_A5A3, 3'h7});
    apb(1'b0, `SSL_ADDR_COUNT, 32'h0);
    chk(rd, 32'h0000_000C);
    // Link off and counter cleared: a whole frame must leave no trace
    apb(1'b1, `SSL_ADDR_CTRL, 32'h0000_0002);
    chk(32'(er), 32'h0);
    u_host.send({3'h0, 26'h000_0000, 3'h7});
    apb(1'b0, 8'h1C, 32'h0);
    chk(rd, {3'h7, 26'h255_A5A3, 3'h7});
    apb(1'b0, `SSL_ADDR_COUNT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `SSL_ADDR_CTRL, 32'h0000_0001);
  endtask

  task t_mux;
    logic [3:0] c;
    integer     k;
    for (k = 0; k < 4; k = k + 1)
    begin
      c = (k < 2) ? 4'(k) : 4'(k + 2);
      LOCK_DETECT_IN     <= 1'b1;
      MODULATION_DATA_IN <= 1'b0;
      u_host.send(w0(c, 12'h064, 12'h000));
      chk(32'(SELECTABLE_MONITOR_OUTPUT), 32'(c == 4'h1 || c == 4'h5));
      LOCK_DETECT_IN     <= 1'b0;
      MODULATION_DATA_IN <= 1'b1;
      repeat (6) @(posedge CLK);
      chk(32'(SELECTABLE_MONITOR_OUTPUT), 32'(c == 4'h4 || c == 4'h5));
      chk(32'(MOD_DATA_OUT), 32'h1);
    end
    // One feedback rise must flip the scaled feedback on the monitor
    u_host.send(w0(4'h2, 12'h064, 12'h000));
    c[0] = SELECTABLE_MONITOR_OUTPUT;
    RF_FEEDBACK_IN <= 1'b1;
    repeat (6) @(posedge CLK);
    RF_FEEDBACK_IN <= 1'b0;
    repeat (6) @(posedge CLK);
    chk(32'(SELECTABLE_MONITOR_OUTPUT), 32'(!c[0]));
  endtask

  // Reference toggles every 5 clocks, so a plain period is 10 clocks
  task t_rate(input logic [4:0] r, input logic d, input logic t, input integer p);
    integer n, k;
    logic   m;
    begin
      n = 0;
      m = 1'b0;
      u_host.send(w2(4'h3, t, d, r));
      u_host.send(w0(4'h3, 12'h064, 12'h000));
      for (k = 0; k < 3; k = k + 1)
      begin
        n = 1;
        do
        begin
          @(posedge CLK);
          n = n + 1;
        end
        while (COMPARE_TICK !== 1'b1 && n < 1000);
        // Monitor shows the scaled reference one clock after the tick
        @(posedge CLK);
        if (k == 1) m = SELECTABLE_MONITOR_OUTPUT;
      end
      chk(32'(n), 32'(p));
      chk(32'(SELECTABLE_MONITOR_OUTPUT), 32'(!m));
    end
  endtask

  task t_power;
    integer k, n;
    begin
      n = 0;
      CHIP_ENABLE <= 1'b0;
      repeat (6) @(posedge CLK);
      chk(32'({POWERED_DOWN, CHARGE_PUMP_OE}), 32'h2);
      for (k = 0; k < 100; k = k + 1)
      begin
        @(posedge CLK);
        if (COMPARE_TICK === 1'b1) n = n + 1;
      end
      chk(32'(n), 32'h0);
      CHIP_ENABLE <= 1'b1;
      repeat (6) @(posedge CLK);
      chk(32'({POWERED_DOWN, CHARGE_PUMP_OE}), 32'h1);
    end
  endtask

  task final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge CLK);
    n_mismatch = n_mismatch + 1;
    $display("[ERR] %0t watchdog expired", $time);
    final_report;
  end

  initial
  begin
    CLK                = 1'b0;
    RESET              = 1'b1;
    PSEL               = 1'b0;
    PENABLE            = 1'b0;
    PWRITE             = 1'b0;
    PADDR              = 8'h00;
    PWDATA             = 32'h0;
    CHIP_ENABLE        = 1'b1;
    MODULATION_DATA_IN = 1'b0;
    REF_IN             = 1'b0;
    LOCK_DETECT_IN     = 1'b0;
    RF_FEEDBACK_IN     = 1'b0;
    n_mismatch         = 0;
    comparisons        = 0;
    n_upd              = 0;
    ref_cnt            = 0;
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    repeat (3) @(posedge CLK);
    t_regs;
    t_dbuf;
    t_select;
    t_mux;
    t_rate(5'h00, 1'b0, 1'b0, 320);
    t_rate(5'h03, 1'b0, 1'b1, 60);
    t_rate(5'h04, 1'b1, 1'b0, 20);
    t_rate(5'h01, 1'b0, 1'b0, 10);
    t_power;
    final_report;
  end
endmodule
